// ===== hw/mavm_monitor.sv
// Access violation monitor: classification, reporting, capture registers
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Capture 24-bit PC into read-only bytes
// - Captured PC is the processor's executing instruction's, on converter faults too
// - PC undefined after error code cleared
// - One 16MB space for three masters
// - Converter, fetch, unmapped illegal per region
// - Flash, info row, read-only writes illegal
// - CPU reserved write only in special mode
// - Flash collision during command is illegal
// - CPU illegal access raises machine exception
// - Debug illegal access sets debug flag
// - Converter illegal access raises error interrupt
// - Illegal prefetch still raises machine exception
// - CPU or converter ECC raises exception
// - Debug ECC only sets debug flags
// - Nonzero error code freezes all captures
// - Writing all ones clears error code
// - Initiator and target fields encoded
// - Access and error type fields encoded
module mavm_monitor
  import mavm_pkg::*;
(
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // Mode strap and flash state
  input wire logic modeStrap,
  input wire logic nvmBusy,
  // Master accesses
  input wire mavm_access_s cpuAccess,
  input wire mavm_access_s adcAccess,
  input wire mavm_access_s dbgAccess,
  // Processor context of the executing instruction
  input wire mavm_addr_t cpuInstrPc,
  input wire logic [15:0] cpuCcr,
  // Register port
  input wire mavm_regbus_s regBus,
  output logic [7:0] rdData,
  // Access gating
  output logic [2:0] accessBlock,
  // Reports
  output logic cpuMachineException,
  output logic adcErrorIrq,
  output logic debugIllegalAccessFlag,
  output logic debugRamFaultFlag,
  output logic debugReadInvalidFlag,
  output logic specialMode
);

  typedef struct packed {
    logic [15:0] errCode;
    logic [15:0] ccr;
    mavm_addr_t pc;
    logic modeNormal;
    logic modeLoaded;
    logic clrArm;
    logic cpuExc;
    logic adcIrq;
    logic dbgIll;
    logic dbgRamF;
    logic dbgRdInv;
    logic [7:0] rdData;
  } mavm_state_s;

  mavm_state_s st_r, st_nxt;
  mavm_access_s acc [3];
  mavm_verdict_s verd [3];
  logic [2:0] bad;
  logic [2:0] ecc;

  assign acc[0] = cpuAccess;
  assign acc[1] = adcAccess;
  assign acc[2] = dbgAccess;

  // Same map for every master; the converter and the processor each add rules of their own
  for (genvar g = 0; g < 3; g++) begin : g_check
    mavm_region_check #(
      .MASTER(2'(g))
    ) u_check (
      .access(acc[g]),
      .specialMode(specialMode),
      .nvmBusy(nvmBusy),
      .verdict(verd[g])
    );
    assign bad[g] = acc[g].valid & !verd[g].legal;
    assign ecc[g] = acc[g].valid & acc[g].eccFault;
  end

  // Illegal accesses never reach the target
  assign accessBlock = bad;

  // Mode bit low means special single-chip
  assign specialMode = !st_r.modeNormal;

  logic rdSel, wrSel, clearHit, capCpu, capAdc;
  logic [15:0] capCode;

  always_comb begin
    st_nxt = st_r;
    st_nxt.cpuExc = 1'b0;
    st_nxt.adcIrq = 1'b0;
    st_nxt.dbgIll = 1'b0;
    st_nxt.dbgRamF = 1'b0;
    st_nxt.dbgRdInv = 1'b0;
    rdSel = regBus.rd;
    wrSel = regBus.wr;
    clearHit = 1'b0;
    capCode = MAVM_EC_RST;
    // Strap caught once, after reset has been released
    if (!st_r.modeLoaded) begin
      st_nxt.modeNormal = modeStrap;
      st_nxt.modeLoaded = 1'b1;
    end
    st_nxt.cpuExc = bad[0] | ecc[0] | ecc[1];
    st_nxt.adcIrq = bad[1];
    st_nxt.dbgIll = bad[2];
    st_nxt.dbgRamF = ecc[2] & (acc[2].acc == MAVM_ACC_STORE);
    st_nxt.dbgRdInv = ecc[2] & (acc[2].acc != MAVM_ACC_STORE);
    // Processor wins when both fault in one cycle
    capCpu = bad[0] | ecc[0];
    capAdc = !capCpu & (bad[1] | ecc[1]);
    if (capCpu) begin
      capCode[MAVM_ITR_POS +: 4] = MAVM_ITR_CPU;
      capCode[MAVM_TGT_POS +: 4] = verd[0].target;
      capCode[MAVM_ACCF_POS +: 4] = acc[0].acc;
      capCode[MAVM_ERRF_POS +: 4] =
        bad[0] ? MAVM_ERR_ILLEGAL : MAVM_ERR_ECC;
    end else if (capAdc) begin
      capCode[MAVM_ITR_POS +: 4] = MAVM_ITR_ADC;
      capCode[MAVM_TGT_POS +: 4] = verd[1].target;
      capCode[MAVM_ACCF_POS +: 4] = acc[1].acc;
      capCode[MAVM_ERRF_POS +: 4] =
        bad[1] ? MAVM_ERR_ILLEGAL : MAVM_ERR_ECC;
    end
    // Two byte writes of all ones, high byte first, clear the code
    if (wrSel) begin
      st_nxt.clrArm = (regBus.addr == MAVM_OFS_ECH) &&
                      (regBus.wdata == MAVM_CLEAR_BYTE);
      clearHit = st_r.clrArm && (regBus.addr == MAVM_OFS_ECL) &&
                 (regBus.wdata == MAVM_CLEAR_BYTE);
      // Only special to normal is a legal mode change
      if (regBus.addr == MAVM_OFS_MODE && regBus.wdata[MAVM_MODE_BIT]) begin
        st_nxt.modeNormal = 1'b1;
      end
    end
    if (st_r.errCode == MAVM_EC_RST && (capCpu | capAdc)) begin
      // Frozen while nonzero
      // A fault beside a clear of a zero code is kept, not lost
      st_nxt.errCode = capCode;
      st_nxt.pc = cpuInstrPc;
      st_nxt.ccr = cpuCcr;
    end else if (clearHit) begin
      st_nxt.errCode = MAVM_EC_RST;
      // PC and CCR keep stale contents, not meaningful
    end
    // Capture bytes have no write path
    if (rdSel) begin
      unique case (regBus.addr)
        MAVM_OFS_ECH: st_nxt.rdData = st_r.errCode[15:8];
        MAVM_OFS_ECL: st_nxt.rdData = st_r.errCode[7:0];
        MAVM_OFS_CCRH: st_nxt.rdData = st_r.ccr[15:8];
        MAVM_OFS_CCRL: st_nxt.rdData = st_r.ccr[7:0];
        MAVM_OFS_MODE: st_nxt.rdData = {st_r.modeNormal, 7'h00};
        MAVM_OFS_PCH: st_nxt.rdData = st_r.pc[23:16];
        MAVM_OFS_PCM: st_nxt.rdData = st_r.pc[15:8];
        MAVM_OFS_PCL: st_nxt.rdData = st_r.pc[7:0];
        default: st_nxt.rdData = MAVM_RD_RST;
      endcase
    end else begin
      st_nxt.rdData = MAVM_RD_RST;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r.errCode <= MAVM_EC_RST;
      st_r.ccr <= MAVM_CCR_RST;
      st_r.pc <= MAVM_PC_RST;
      st_r.modeNormal <= 1'b1;
      st_r.modeLoaded <= 1'b0;
      st_r.clrArm <= 1'b0;
      st_r.cpuExc <= 1'b0;
      st_r.adcIrq <= 1'b0;
      st_r.dbgIll <= 1'b0;
      st_r.dbgRamF <= 1'b0;
      st_r.dbgRdInv <= 1'b0;
      st_r.rdData <= MAVM_RD_RST;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;
  assign cpuMachineException = st_r.cpuExc;
  assign adcErrorIrq = st_r.adcIrq;
  assign debugIllegalAccessFlag = st_r.dbgIll;
  assign debugRamFaultFlag = st_r.dbgRamF;
  assign debugReadInvalidFlag = st_r.dbgRdInv;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_PC_CAPTURE: assert property (
    ce && st_r.errCode == MAVM_EC_RST && bad[0]
    |=> st_r.pc == $past(cpuInstrPc) && st_r.errCode != MAVM_EC_RST)
    else $error("PC not captured on processor violation");

  AST_FREEZE: assert property (
    st_r.errCode != MAVM_EC_RST && !clearHit
    |=> $stable(st_r.pc) && $stable(st_r.errCode) && $stable(st_r.ccr))
    else $error("Capture changed while error code nonzero");

  AST_CPU_EXC: assert property (
    ce && bad[0] |=> cpuMachineException)
    else $error("Processor violation without machine exception");

  AST_ADC_IRQ: assert property (
    ce && bad[1] |=> adcErrorIrq)
    else $error("Converter violation without error interrupt");

  AST_LEGAL_QUIET: assert property (
    ce && !bad[0] && !ecc[0] && !ecc[1] |=> !cpuMachineException)
    else $error("Machine exception without a fault");

  AST_ADC_QUIET: assert property (
    ce && !bad[1] |=> !adcErrorIrq)
    else $error("Converter interrupt without a violation");

  AST_DBG_QUIET: assert property (
    ce && !bad[2] |=> !debugIllegalAccessFlag)
    else $error("Debug flag without a violation");

  AST_PREFETCH: assert property (
    cpuAccess.valid && cpuAccess.acc == MAVM_ACC_OPCODE &&
    cpuAccess.addr <= MAVM_REG_HI |-> accessBlock[0])
    else $error("Fetch from register space not flagged");

  AST_UNMAPPED: assert property (
    dbgAccess.valid && dbgAccess.addr > MAVM_RSV_HI &&
    dbgAccess.addr < MAVM_PF_LO |-> accessBlock[2])
    else $error("Unmapped access not flagged");

  AST_RAM_OPEN: assert property (
    adcAccess.valid && adcAccess.addr >= MAVM_RAM_LO &&
    adcAccess.addr <= MAVM_RAM_HI |-> !accessBlock[1])
    else $error("RAM access refused");

  AST_RD_IDLE: assert property (
    ce && !regBus.rd |=> rdData == MAVM_RD_RST)
    else $error("Read data outside the answer cycle");

  AST_CODE_FIELDS: assert property (
    ce && st_r.errCode == MAVM_EC_RST && (capCpu || capAdc)
    |=> st_r.errCode[MAVM_ITR_POS +: 4] != 4'h0 &&
      st_r.errCode[MAVM_ERRF_POS +: 4] != 4'h0)
    else $error("Captured code lacks initiator or error type");

  AST_DBG_ONLY: assert property (
    ce && bad[2] && !bad[0] && !ecc[0] && !ecc[1]
    |=> debugIllegalAccessFlag && !cpuMachineException)
    else $error("Debug violation reported wrongly");

  AST_DBG_ECC: assert property (
    ce && ecc[2] && !bad[0] && !ecc[0] && !ecc[1]
    |=> (debugRamFaultFlag ^ debugReadInvalidFlag) && !cpuMachineException)
    else $error("Debug ECC fault reported wrongly");

  AST_ECC_EXC: assert property (
    ce && (ecc[0] || ecc[1]) |=> cpuMachineException)
    else $error("ECC fault without machine exception");

  AST_CLEAR: assert property (
    ce && clearHit && !(st_r.errCode == MAVM_EC_RST && (capCpu || capAdc))
    |=> st_r.errCode == MAVM_EC_RST)
    else $error("Error code not cleared");

  AST_FLASH_WRITE: assert property (
    cpuAccess.valid && cpuAccess.acc == MAVM_ACC_STORE &&
    cpuAccess.addr >= MAVM_PF_LO |-> accessBlock[0])
    else $error("Flash write not blocked");

  AST_RSV_WRITE: assert property (
    cpuAccess.valid && cpuAccess.acc == MAVM_ACC_STORE && !specialMode &&
    cpuAccess.addr >= MAVM_RSV_LO && cpuAccess.addr <= MAVM_RSV_HI
    |-> accessBlock[0])
    else $error("Reserved write allowed outside special mode");

  AST_COLLISION: assert property (
    nvmBusy && adcAccess.valid && adcAccess.addr >= MAVM_PF_LO
    |-> accessBlock[1])
    else $error("Flash collision not flagged");

  COV_CPU_FAULT: cover property (ce && bad[0] ##1 cpuMachineException);
  COV_CLEAR: cover property (ce && clearHit);
  COV_DBG_FAULT: cover property (ce && bad[2] ##1 debugIllegalAccessFlag);
  COV_ADC_ECC: cover property (ce && ecc[1] ##1 cpuMachineException);
  COV_COLLISION: cover property (ce && nvmBusy && (bad != 3'h0));

endmodule : mavm_monitor
`default_nettype wire

// ===== hw/mavm_pkg.sv
// Shared constants and types of the memory access violation monitor
package mavm_pkg;

  // One flat 16MB space shared by all masters
  localparam int MAVM_ADDR_W = 24;
  typedef logic [MAVM_ADDR_W-1:0] mavm_addr_t;

  typedef enum logic [3:0] {
    MAVM_ACC_NONE = 4'h0,
    MAVM_ACC_OPCODE = 4'h1,
    MAVM_ACC_VECTOR = 4'h2,
    MAVM_ACC_LOAD = 4'h3,
    MAVM_ACC_STORE = 4'h4
  } mavm_acc_e;

  // Master indices, also decoder parameter
  localparam logic [1:0] MAVM_M_CPU = 2'h0;
  localparam logic [1:0] MAVM_M_ADC = 2'h1;
  localparam logic [1:0] MAVM_M_DBG = 2'h2;

  // Error code fields
  localparam logic [3:0] MAVM_ITR_CPU = 4'h1;
  localparam logic [3:0] MAVM_ITR_ADC = 4'h3;
  localparam logic [3:0] MAVM_TGT_NONE = 4'h0;
  localparam logic [3:0] MAVM_TGT_REG = 4'h1;
  localparam logic [3:0] MAVM_TGT_RAM = 4'h2;
  localparam logic [3:0] MAVM_TGT_DFLASH = 4'h3;
  localparam logic [3:0] MAVM_TGT_PFLASH = 4'h4;
  localparam logic [3:0] MAVM_TGT_IFR = 4'h5;
  localparam logic [3:0] MAVM_ERR_ILLEGAL = 4'h1;
  localparam logic [3:0] MAVM_ERR_ECC = 4'h2;
  localparam int MAVM_ITR_POS = 12;
  localparam int MAVM_TGT_POS = 8;
  localparam int MAVM_ACCF_POS = 4;
  localparam int MAVM_ERRF_POS = 0;

  // Region bounds, inclusive
  localparam mavm_addr_t MAVM_REG_LO = 24'h000000;
  localparam mavm_addr_t MAVM_REG_HI = 24'h000FFF;
  localparam mavm_addr_t MAVM_RAM_LO = 24'h001000;
  localparam mavm_addr_t MAVM_RAM_HI = 24'h002FFF;
  localparam mavm_addr_t MAVM_DF_LO = 24'h100000;
  localparam mavm_addr_t MAVM_DF_HI = 24'h1007FF;
  localparam mavm_addr_t MAVM_IFR_LO = 24'h1F0000;
  localparam mavm_addr_t MAVM_IFR_HI = 24'h1F7FFF;
  localparam mavm_addr_t MAVM_RSVRO_LO = 24'h1F8000;
  localparam mavm_addr_t MAVM_RSVRO_HI = 24'h1FFFFF;
  localparam mavm_addr_t MAVM_RSV_LO = 24'h200000;
  localparam mavm_addr_t MAVM_RSV_HI = 24'h3FFFFF;
  localparam mavm_addr_t MAVM_PF_LO = 24'hFC0000;
  localparam mavm_addr_t MAVM_PF_HI = 24'hFFFFFF;

  // Register offsets
  localparam logic [3:0] MAVM_OFS_ECH = 4'h0;
  localparam logic [3:0] MAVM_OFS_ECL = 4'h1;
  localparam logic [3:0] MAVM_OFS_CCRH = 4'h2;
  localparam logic [3:0] MAVM_OFS_CCRL = 4'h3;
  localparam logic [3:0] MAVM_OFS_MODE = 4'h4;
  localparam logic [3:0] MAVM_OFS_PCH = 4'h5;
  localparam logic [3:0] MAVM_OFS_PCM = 4'h6;
  localparam logic [3:0] MAVM_OFS_PCL = 4'h7;
  localparam int MAVM_MODE_BIT = 7;
  localparam logic [7:0] MAVM_CLEAR_BYTE = 8'hFF;

  // Reset values
  localparam logic [15:0] MAVM_EC_RST = 16'h0000;
  localparam logic [15:0] MAVM_CCR_RST = 16'h0000;
  localparam mavm_addr_t MAVM_PC_RST = 24'h000000;
  localparam logic [7:0] MAVM_RD_RST = 8'h00;

  typedef struct packed {
    logic valid;
    mavm_acc_e acc;
    mavm_addr_t addr;
    logic eccFault;
  } mavm_access_s;

  typedef struct packed {
    logic legal;
    logic [3:0] target;
  } mavm_verdict_s;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mavm_regbus_s;

endpackage : mavm_pkg

// ===== hw/mavm_region_check.sv
// Per-master legality check of one access against the global map
`timescale 1ns/1ps
`default_nettype none
module mavm_region_check
  import mavm_pkg::*;
#(
  parameter logic [1:0] MASTER = MAVM_M_CPU
) (
  // Access and context
  input wire mavm_access_s access,
  input wire logic specialMode,
  input wire logic nvmBusy,
  // Result
  output mavm_verdict_s verdict
);

  function automatic logic inside_range(mavm_addr_t a, mavm_addr_t lo,
                                        mavm_addr_t hi);
    inside_range = (a >= lo) && (a <= hi);
  endfunction : inside_range

  logic isReg, isRam, isDf, isIfr, isRsvRo, isRsv, isPf, isMapped;
  logic isWrite, isExec, isAdc, isCpu, bad;

  always_comb begin
    isReg = inside_range(access.addr, MAVM_REG_LO, MAVM_REG_HI);
    isRam = inside_range(access.addr, MAVM_RAM_LO, MAVM_RAM_HI);
    isDf = inside_range(access.addr, MAVM_DF_LO, MAVM_DF_HI);
    isIfr = inside_range(access.addr, MAVM_IFR_LO, MAVM_IFR_HI);
    isRsvRo = inside_range(access.addr, MAVM_RSVRO_LO, MAVM_RSVRO_HI);
    isRsv = inside_range(access.addr, MAVM_RSV_LO, MAVM_RSV_HI);
    isPf = inside_range(access.addr, MAVM_PF_LO, MAVM_PF_HI);
    isMapped = isReg | isRam | isDf | isIfr | isRsvRo | isRsv | isPf;
    isWrite = access.acc == MAVM_ACC_STORE;
    // Prefetches count like executed fetches
    isExec = access.acc == MAVM_ACC_OPCODE;
    isAdc = MASTER == MAVM_M_ADC;
    isCpu = MASTER == MAVM_M_CPU;
    bad = !isMapped;
    bad |= isAdc & (isReg | isRsv | isRsvRo | isIfr);
    bad |= isExec & !(isRam | isDf | isPf);
    bad |= isWrite & (isDf | isIfr | isPf | isRsvRo);
    bad |= isCpu & isWrite & isRsv & !specialMode;
    // Any flash access during a command counts as a collision
    bad |= nvmBusy & (isDf | isPf | isIfr);
    verdict.legal = !bad;
    verdict.target = isReg ? MAVM_TGT_REG :
                     isRam ? MAVM_TGT_RAM :
                     isDf ? MAVM_TGT_DFLASH :
                     isPf ? MAVM_TGT_PFLASH :
                     isIfr ? MAVM_TGT_IFR : MAVM_TGT_NONE;
  end

endmodule : mavm_region_check
`default_nettype wire

// ===== testbench/mavm_master_model.sv
// Behavioural model of the three bus masters and the core's PC output
`timescale 1ns/1ps
`default_nettype none
module mavm_master_model
  import mavm_pkg::*;
(
  // Clock and request from the bench
  input wire logic clk,
  input wire mavm_access_s req,
  input wire logic [1:0] reqMaster,
  input wire mavm_addr_t reqPc,
  // Master side of the monitor
  output mavm_access_s cpuAccess,
  output mavm_access_s adcAccess,
  output mavm_access_s dbgAccess,
  output mavm_addr_t cpuInstrPc
);
  mavm_access_s acc[3] = '{default: '0};
  mavm_addr_t pcR = '0;
  // Idle masters show a toggling address, so no stale address looks valid
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (req.valid && reqMaster == 2'(i)) begin
        acc[i] <= req;
      end else begin
        acc[i] <= '{1'b0, MAVM_ACC_NONE, ~acc[i].addr, 1'b0};
      end
    end
    // Owner instruction address, never the prefetch address
    pcR <= reqPc;
  end
  assign cpuAccess = acc[0];
  assign adcAccess = acc[1];
  assign dbgAccess = acc[2];
  assign cpuInstrPc = pcR;
endmodule : mavm_master_model
`default_nettype wire

// ===== testbench/memory_access_violation_monitor_bench.sv
// Self-checking bench of the access violation monitor
`timescale 1ns/1ps
`default_nettype none
module memory_access_violation_monitor_bench;
  import mavm_pkg::*;
  typedef struct packed {
    logic [1:0] m;
    logic [3:0] acc;
    mavm_addr_t addr;
    logic blk;
    logic [15:0] ec;
  } mavm_row_s;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic modeStrap = 1'b1;
  logic nvmBusy = 1'b0;
  mavm_access_s req = '0;
  logic [1:0] reqMaster = 2'h0;
  mavm_addr_t reqPc = 24'h000000;
  logic [15:0] cpuCcr = 16'h5A5A;
  mavm_regbus_s regBus = '0;
  mavm_access_s cpuAccess, adcAccess, dbgAccess;
  mavm_addr_t cpuInstrPc;
  logic [7:0] rdData;
  logic [2:0] accessBlock;
  logic cpuMachineException, adcErrorIrq, debugIllegalAccessFlag;
  logic debugRamFaultFlag, debugReadInvalidFlag, specialMode;
  int errCount = 0;
  int checked = 0;
  // Opcode fetches stay clear of the last 8 bytes of each region
  mavm_row_s rows[28] = '{
    '{2'h0, 4'h1, 24'h000000, 1'b1, 16'h1111},
    '{2'h0, 4'h3, 24'h000010, 1'b0, 16'h0000},
    '{2'h0, 4'h4, 24'h002FF0, 1'b0, 16'h0000},
    '{2'h0, 4'h1, 24'h001000, 1'b0, 16'h0000},
    '{2'h0, 4'h4, 24'h100000, 1'b1, 16'h1341},
    '{2'h0, 4'h1, 24'h100100, 1'b0, 16'h0000},
    '{2'h0, 4'h2, 24'hFFFFFC, 1'b0, 16'h0000},
    '{2'h0, 4'h4, 24'hFC0000, 1'b1, 16'h1441},
    '{2'h0, 4'h1, 24'h1F0000, 1'b1, 16'h1511},
    '{2'h0, 4'h3, 24'h1F0000, 1'b0, 16'h0000},
    '{2'h0, 4'h4, 24'h1F8000, 1'b1, 16'h1041},
    '{2'h0, 4'h3, 24'h1FFFFF, 1'b0, 16'h0000},
    '{2'h0, 4'h4, 24'h200000, 1'b1, 16'h1041},
    '{2'h0, 4'h1, 24'h3FFFF0, 1'b1, 16'h1011},
    '{2'h0, 4'h3, 24'h800000, 1'b1, 16'h1031},
    '{2'h1, 4'h3, 24'h000100, 1'b1, 16'h3131},
    '{2'h1, 4'h4, 24'h001800, 1'b0, 16'h0000},
    '{2'h1, 4'h3, 24'h1007F0, 1'b0, 16'h0000},
    '{2'h1, 4'h3, 24'h1F4000, 1'b1, 16'h3531},
    '{2'h1, 4'h3, 24'h200000, 1'b1, 16'h3031},
    '{2'h1, 4'h4, 24'hFC0000, 1'b1, 16'h3441},
    '{2'h1, 4'h3, 24'hFC1000, 1'b0, 16'h0000},
    '{2'h2, 4'h4, 24'h000020, 1'b0, 16'h0000},
    '{2'h2, 4'h4, 24'h3FFFFF, 1'b0, 16'h0000},
    '{2'h2, 4'h3, 24'h1F0000, 1'b0, 16'h0000},
    '{2'h2, 4'h4, 24'h1F0000, 1'b1, 16'h0000},
    '{2'h2, 4'h3, 24'h800000, 1'b1, 16'h0000},
    '{2'h2, 4'h4, 24'h1F8000, 1'b1, 16'h0000}};

  mavm_master_model i_masters (.clk(clk), .req(req), .reqMaster(reqMaster),
    .reqPc(reqPc), .cpuAccess(cpuAccess), .adcAccess(adcAccess),
    .dbgAccess(dbgAccess), .cpuInstrPc(cpuInstrPc));
  mavm_monitor i_dut (.clk(clk), .reset(reset), .ce(ce),
    .modeStrap(modeStrap), .nvmBusy(nvmBusy), .cpuAccess(cpuAccess),
    .adcAccess(adcAccess), .dbgAccess(dbgAccess), .cpuInstrPc(cpuInstrPc),
    .cpuCcr(cpuCcr), .regBus(regBus), .rdData(rdData),
    .accessBlock(accessBlock), .cpuMachineException(cpuMachineException),
    .adcErrorIrq(adcErrorIrq),
    .debugIllegalAccessFlag(debugIllegalAccessFlag),
    .debugRamFaultFlag(debugRamFaultFlag),
    .debugReadInvalidFlag(debugReadInvalidFlag), .specialMode(specialMode));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  task automatic doReset(input logic strap);
    reset <= 1'b1;
    modeStrap <= strap;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : doReset

  task automatic regWr(input logic [3:0] a, input logic [7:0] d);
    regBus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    regBus <= '0;
    @(posedge clk);
  endtask : regWr

  task automatic regRd(input logic [3:0] a, output logic [7:0] d);
    regBus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    regBus <= '0;
    #1 d = rdData;
    @(posedge clk);
  endtask : regRd

  // Both halves back to back; any write between them, except all ones to the high byte, would disarm
  task automatic ecClear();
    regBus <= '{MAVM_OFS_ECH, MAVM_CLEAR_BYTE, 1'b1, 1'b0};
    @(posedge clk);
    regBus <= '{MAVM_OFS_ECL, MAVM_CLEAR_BYTE, 1'b1, 1'b0};
    @(posedge clk);
    regBus <= '0;
    @(posedge clk);
  endtask : ecClear

  task automatic readEc(output logic [15:0] v);
    regRd(MAVM_OFS_ECH, v[15:8]);
    regRd(MAVM_OFS_ECL, v[7:0]);
  endtask : readEc

  task automatic readPc(output logic [23:0] v);
    regRd(MAVM_OFS_PCH, v[23:16]);
    regRd(MAVM_OFS_PCM, v[15:8]);
    regRd(MAVM_OFS_PCL, v[7:0]);
  endtask : readPc

  // Seen: block bit, then exception, irq, illegal, ram fault, read invalid
  task automatic access(input logic [1:0] m, input mavm_acc_e a,
      input mavm_addr_t ad, input logic e, output logic [5:0] seen);
    req <= '{1'b1, a, ad, e};
    reqMaster <= m;
    @(posedge clk);
    req.valid <= 1'b0;
    #1 seen[5] = accessBlock[m];
    @(posedge clk);
    #1 seen[4:0] = {cpuMachineException, adcErrorIrq,
      debugIllegalAccessFlag, debugRamFaultFlag, debugReadInvalidFlag};
    @(posedge clk);
  endtask : access

  initial begin
    logic [5:0] s;
    logic [15:0] ec;
    logic [23:0] pc;
    logic [7:0] d;
    doReset(1'b1);
    readEc(ec);
    check(ec, MAVM_EC_RST);
    readPc(pc);
    check(pc, MAVM_PC_RST);
    regRd(4'hF, d);
    check(d, MAVM_RD_RST);
    foreach (rows[i]) begin
      access(rows[i].m, mavm_acc_e'(rows[i].acc), rows[i].addr, 1'b0, s);
      check(s, {rows[i].blk, rows[i].blk ? 5'h10 >> rows[i].m : 5'h00});
      if (rows[i].blk) begin
        readEc(ec);
        check(ec, rows[i].ec);
        ecClear();
      end
    end
    // Capture, then a second fault that must not overwrite it
    reqPc <= 24'hABC123;
    access(MAVM_M_CPU, MAVM_ACC_STORE, MAVM_PF_LO, 1'b0, s);
    readPc(pc);
    check(pc, 24'hABC123);
    regRd(MAVM_OFS_CCRH, d);
    check(d, 8'h5A);
    cpuCcr <= 16'hC3C3;
    regWr(MAVM_OFS_PCH, 8'h00);
    reqPc <= 24'h456DEF;
    access(MAVM_M_CPU, MAVM_ACC_OPCODE, MAVM_REG_LO, 1'b0, s);
    check(s, 6'h30);
    readEc(ec);
    check(ec, 16'h1441);
    readPc(pc);
    check(pc, 24'hABC123);
    regRd(MAVM_OFS_CCRL, d);
    check(d, 8'h5A);
    // Interrupted clear sequence leaves the code in place
    regWr(MAVM_OFS_ECH, MAVM_CLEAR_BYTE);
    regWr(MAVM_OFS_PCM, 8'h00);
    regWr(MAVM_OFS_ECL, MAVM_CLEAR_BYTE);
    readEc(ec);
    check(ec, 16'h1441);
    ecClear();
    readEc(ec);
    check(ec, MAVM_EC_RST);
    // Uncorrectable ECC per master
    access(MAVM_M_ADC, MAVM_ACC_LOAD, MAVM_RAM_LO, 1'b1, s);
    check(s[4:0], 5'h10);
    readEc(ec);
    check(ec, 16'h3232);
    ecClear();
    reqPc <= 24'h0F0F0F;
    access(MAVM_M_CPU, MAVM_ACC_OPCODE, MAVM_RAM_LO, 1'b1, s);
    check(s[4:0], 5'h10);
    readEc(ec);
    check(ec, 16'h1212);
    readPc(pc);
    check(pc, 24'h0F0F0F);
    ecClear();
    access(MAVM_M_DBG, MAVM_ACC_STORE, MAVM_RAM_LO, 1'b1, s);
    check(s[4:0], 5'h02);
    access(MAVM_M_DBG, MAVM_ACC_LOAD, MAVM_DF_LO, 1'b1, s);
    check(s[4:0], 5'h01);
    readEc(ec);
    check(ec, MAVM_EC_RST);
    // Enable low: still blocked, but no report and no capture
    ce <= 1'b0;
    access(MAVM_M_CPU, MAVM_ACC_STORE, MAVM_PF_LO, 1'b0, s);
    check(s, 6'h20);
    ce <= 1'b1;
    readEc(ec);
    check(ec, MAVM_EC_RST);
    // Flash collisions while a command runs
    nvmBusy <= 1'b1;
    access(MAVM_M_DBG, MAVM_ACC_LOAD, MAVM_DF_LO, 1'b0, s);
    check(s, 6'h24);
    access(MAVM_M_ADC, MAVM_ACC_LOAD, MAVM_RAM_LO, 1'b0, s);
    check(s, 6'h00);
    access(MAVM_M_CPU, MAVM_ACC_LOAD, MAVM_PF_LO, 1'b0, s);
    check(s, 6'h30);
    readEc(ec);
    check(ec, 16'h1431);
    nvmBusy <= 1'b0;
    // Second reset in mid-run, into special single-chip mode
    doReset(1'b0);
    #1 check(specialMode, 1'b1);
    @(posedge clk);
    readEc(ec);
    check(ec, MAVM_EC_RST);
    access(MAVM_M_CPU, MAVM_ACC_STORE, MAVM_RSV_LO, 1'b0, s);
    check(s, 6'h00);
    regWr(MAVM_OFS_MODE, 8'h80);
    #1 check(specialMode, 1'b0);
    @(posedge clk);
    access(MAVM_M_CPU, MAVM_ACC_STORE, MAVM_RSV_LO, 1'b0, s);
    check(s, 6'h30);
    conclude();
  end

  // Whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    conclude();
  end
endmodule : memory_access_violation_monitor_bench
`default_nettype wire
